/* File: hw/tdm_host_port.sv */
// Host parallel port of the time-slot switch: bus styles, memories, DMA and error
`timescale 1ns/1ns
module tdm_host_port #(
  parameter int DMA_CH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] adIn,
  output logic [7:0] adOut,
  output logic adOe,
  input wire logic [1:0] regSel,
  input wire logic ale,
  input wire logic csN,
  input wire logic readDataStrobeN,
  input wire logic writeRwN,
  output logic rdyTransferAckOut,
  output logic rdyTransferAckOe,
  input wire logic bus4MhzClock,
  input wire logic pllLocked,
  output logic errOut,
  output logic [DMA_CH-1:0] dmaRequestLine,
  input wire logic [DMA_CH-1:0] dmaAckLine
);
  localparam int IW = $clog2(tdm_host_pkg::CHANNELS);
  localparam int FW = $clog2(tdm_host_pkg::FRAME_CYC);
  localparam int LW = $clog2(tdm_host_pkg::LOSS_CYC + 1);
  typedef enum logic [1:0] {ACC_CLEAR, ACC_IDLE, ACC_EXEC, ACC_DONE} accState_e;

  initial begin
    if (DMA_CH < 1 || DMA_CH > 6) $error("DMA_CH must be 1..6");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin passes two flops; stage one feeds nothing but stage two
  tdm_host_pkg::hostPins_s pinRaw, pinA_q, pin_q;
  logic [DMA_CH-1:0] ackA_q, ack_q, ackOld_q;
  logic [2:0] bclk_q;
  logic lockA_q, lock_q, aleOld_q;
  assign pinRaw = '{csN, readDataStrobeN, writeRwN, ale, regSel, adIn};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinA_q <= '1;
      pin_q <= '1;
      ackA_q <= '0;
      ack_q <= '0;
      ackOld_q <= '0;
      bclk_q <= '0;
      lockA_q <= 1'b0;
      lock_q <= 1'b0;
      aleOld_q <= 1'b1;
    end else begin
      pinA_q <= pinRaw;
      pin_q <= pinA_q;
      ackA_q <= dmaAckLine;
      ack_q <= ackA_q;
      ackOld_q <= ack_q;
      bclk_q <= {bclk_q[1:0], bus4MhzClock};
      lockA_q <= pllLocked;
      lock_q <= lockA_q;
      aleOld_q <= pin_q.ale;
    end
  end

  // ----------------------------------------------------------------
  // Bus style and address path
  // ----------------------------------------------------------------
  tdm_host_pkg::busStyle_e style_q, style_d;
  logic [1:0] addrLatch_q, addrLatch_d, regAddr;
  logic aleFall, active, isRead;
  accState_e state_q, state_d;
  assign aleFall = aleOld_q && !pin_q.ale;
  // Strap caught at end of the clear sweep; a falling strobe means multiplexed
  always_comb begin
    style_d = style_q;
    addrLatch_d = addrLatch_q;
    if (state_q == ACC_CLEAR) begin
      style_d = pin_q.ale ? tdm_host_pkg::STYLE_READY : tdm_host_pkg::STYLE_ACK;
    end
    if (aleFall && state_q != ACC_CLEAR) begin
      style_d = tdm_host_pkg::STYLE_MUX;
      addrLatch_d = pin_q.ad[1:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      style_q <= tdm_host_pkg::STYLE_ACK;
      addrLatch_q <= 2'h0;
    end else begin
      style_q <= style_d;
      addrLatch_q <= addrLatch_d;
    end
  end
  // Select lines are not looked at in multiplexed style
  assign regAddr = (style_q == tdm_host_pkg::STYLE_MUX) ? addrLatch_q : pin_q.regSel;
  // Chip select gates the read and write strobes; acknowledge style needs strobe and select together
  always_comb begin
    if (style_q == tdm_host_pkg::STYLE_ACK) begin
      active = !pin_q.csN && !pin_q.rdN;
      isRead = pin_q.wrN;
    end else begin
      active = !pin_q.csN && (!pin_q.rdN || !pin_q.wrN);
      isRead = !pin_q.rdN;
    end
  end

  // ----------------------------------------------------------------
  // Access engine, registers and memories
  // ----------------------------------------------------------------
  logic [7:0] dataMem [tdm_host_pkg::CHANNELS];
  logic [11:0] connMem [tdm_host_pkg::CHANNELS];
  logic [IW-1:0] clrIdx_q, clrIdx_d, memIdx;
  logic [7:0] idxLow_q, idxLow_d, idxHigh_q, idxHigh_d, ctrl_q, ctrl_d;
  logic [7:0] cmTemp_q, cmTemp_d, rdData_q, rdData_d, wrData_q, wrData_d, status;
  logic [1:0] acc_q, acc_d, space;
  logic accRd_q, accRd_d, idxOk, dmWr, cmWr, clrOvr;
  logic [DMA_CH-1:0] ovr_q;
  logic lossErr;
  assign memIdx = IW'({idxHigh_q[tdm_host_pkg::IDX_MSB_BIT], idxLow_q});
  assign idxOk = int'(memIdx) < tdm_host_pkg::CHANNELS;
  assign space = idxHigh_q[tdm_host_pkg::SPACE_LSB +: 2];
  assign status = {lossErr, !lock_q, 6'(ovr_q)};
  // Pins are captured once per strobe; the memory step runs one cycle later
  always_comb begin
    state_d = state_q;
    clrIdx_d = clrIdx_q;
    acc_d = acc_q;
    accRd_d = accRd_q;
    wrData_d = wrData_q;
    rdData_d = rdData_q;
    idxLow_d = idxLow_q;
    idxHigh_d = idxHigh_q;
    ctrl_d = ctrl_q;
    cmTemp_d = cmTemp_q;
    dmWr = 1'b0;
    cmWr = 1'b0;
    clrOvr = 1'b0;
    unique case (state_q)
      ACC_CLEAR: begin
        clrIdx_d = clrIdx_q + 1'b1;
        if (int'(clrIdx_q) == tdm_host_pkg::CHANNELS - 1) begin
          state_d = ACC_IDLE;
        end
      end
      ACC_IDLE: begin
        if (active) begin
          acc_d = regAddr;
          accRd_d = isRead;
          wrData_d = pin_q.ad;
          state_d = ACC_EXEC;
        end
      end
      ACC_EXEC: begin
        state_d = ACC_DONE;
        if (accRd_q) begin
          unique case (acc_q)
            tdm_host_pkg::REG_IDX_LOW: rdData_d = idxLow_q;
            tdm_host_pkg::REG_IDX_HIGH: rdData_d = idxHigh_q;
            tdm_host_pkg::REG_CTRL: rdData_d = ctrl_q;
            tdm_host_pkg::REG_DATA: begin
              unique case (space)
                tdm_host_pkg::SPACE_REG: rdData_d = status;
                tdm_host_pkg::SPACE_DM: rdData_d = idxOk ? dataMem[memIdx] : 8'h00;
                tdm_host_pkg::SPACE_CML: rdData_d = idxOk ? connMem[memIdx][7:0] : 8'h00;
                tdm_host_pkg::SPACE_CMH: rdData_d = idxOk ? {4'h0, connMem[memIdx][11:8]} : 8'h00;
              endcase
            end
          endcase
        end else begin
          unique case (acc_q)
            tdm_host_pkg::REG_IDX_LOW: idxLow_d = wrData_q;
            tdm_host_pkg::REG_IDX_HIGH: idxHigh_d = wrData_q;
            tdm_host_pkg::REG_CTRL: begin
              ctrl_d = wrData_q & 8'h7f;
              clrOvr = wrData_q[tdm_host_pkg::CTRL_CLR_OVR_BIT];
            end
            tdm_host_pkg::REG_DATA: begin
              dmWr = (space == tdm_host_pkg::SPACE_DM) && idxOk;
              cmWr = (space == tdm_host_pkg::SPACE_CMH) && idxOk;
              if (space == tdm_host_pkg::SPACE_CML) begin
                cmTemp_d = wrData_q;
              end
            end
          endcase
        end
      end
      ACC_DONE: begin
        if (!active) begin
          state_d = ACC_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ACC_CLEAR;
      clrIdx_q <= '0;
      acc_q <= 2'h0;
      accRd_q <= 1'b0;
      wrData_q <= 8'h00;
      rdData_q <= 8'h00;
      idxLow_q <= tdm_host_pkg::IDX_RST;
      idxHigh_q <= tdm_host_pkg::IDX_RST;
      ctrl_q <= tdm_host_pkg::CTRL_RST;
      cmTemp_q <= 8'h00;
    end else begin
      state_q <= state_d;
      clrIdx_q <= clrIdx_d;
      acc_q <= acc_d;
      accRd_q <= accRd_d;
      wrData_q <= wrData_d;
      rdData_q <= rdData_d;
      idxLow_q <= idxLow_d;
      idxHigh_q <= idxHigh_d;
      ctrl_q <= ctrl_d;
      cmTemp_q <= cmTemp_d;
    end
  end
  // Memories are wiped by a sweep, far cheaper than resetting 384 words at once
  always_ff @(posedge clk) begin
    if (state_q == ACC_CLEAR) begin
      dataMem[clrIdx_q] <= 8'h00;
      connMem[clrIdx_q] <= 12'h000;
    end else begin
      if (dmWr) begin
        dataMem[memIdx] <= wrData_q;
      end
      if (cmWr) begin
        connMem[memIdx] <= {wrData_q[3:0], cmTemp_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Ready stays low through the sweep too, so early accesses just wait
  assign adOut = rdData_q;
  assign adOe = active && isRead && (state_q == ACC_DONE);
  assign rdyTransferAckOut = 1'b0;
  always_comb begin
    if (style_q == tdm_host_pkg::STYLE_ACK) begin
      rdyTransferAckOe = active && state_q == ACC_DONE;
    end else begin
      rdyTransferAckOe = active && state_q != ACC_DONE;
    end
  end

  // ----------------------------------------------------------------
  // Frame tick, DMA and error
  // ----------------------------------------------------------------
  logic [FW-1:0] frame_q, frame_d;
  logic [LW-1:0] loss_q, loss_d;
  logic tick;
  assign tick = int'(frame_q) == tdm_host_pkg::FRAME_CYC - 1;
  // One request per 8 kHz frame; bus clock idle too long counts as lost
  always_comb begin
    frame_d = tick ? '0 : frame_q + 1'b1;
    loss_d = loss_q;
    if (bclk_q[2] != bclk_q[1]) begin
      loss_d = '0;
    end else if (!lossErr) begin
      loss_d = loss_q + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= '0;
      loss_q <= '0;
    end else begin
      frame_q <= frame_d;
      loss_q <= loss_d;
    end
  end
  assign lossErr = int'(loss_q) == tdm_host_pkg::LOSS_CYC;
  assign errOut = lossErr || (|ovr_q) || !lock_q;

  // A fresh frame while the old request is unanswered is an overrun
  for (genvar c = 0; c < DMA_CH; c++) begin : g_dma
    logic req_q, req_d, ovr_d, ovrOne_q;
    always_comb begin
      req_d = req_q;
      ovr_d = ovrOne_q;
      if (clrOvr) begin
        ovr_d = 1'b0;
      end
      if (ack_q[c] && !ackOld_q[c]) begin
        req_d = 1'b0;
      end
      if (tick && ctrl_q[c]) begin
        ovr_d = ovrOne_q || req_q;
        req_d = 1'b1;
      end
      if (!ctrl_q[c]) begin
        req_d = 1'b0;
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        req_q <= 1'b0;
        ovrOne_q <= 1'b0;
      end else begin
        req_q <= req_d;
        ovrOne_q <= ovr_d;
      end
    end
    assign ovr_q[c] = ovrOne_q;
    assign dmaRequestLine[c] = req_q;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_when_done: assert property (style_q == tdm_host_pkg::STYLE_ACK && rdyTransferAckOe |-> state_q == ACC_DONE && active)
    else $error("ack without finished access");
  a_ready_wait: assert property (style_q != tdm_host_pkg::STYLE_ACK && active && state_q == ACC_IDLE |-> rdyTransferAckOe)
    else $error("ready not held low");
  a_cs_ignored: assert property (pin_q.csN && state_q == ACC_IDLE |=> state_q == ACC_IDLE)
    else $error("access taken without select");
  a_cm_commit: assert property (state_q == ACC_EXEC && cmWr |=> connMem[$past(memIdx)] == {$past(wrData_q[3:0]), $past(cmTemp_q)})
    else $error("connection word not committed");
  a_cml_hold: assert property (state_q == ACC_EXEC && !accRd_q && acc_q == tdm_host_pkg::REG_DATA && space == tdm_host_pkg::SPACE_CML |=> cmTemp_q == $past(wrData_q) && !$past(cmWr))
    else $error("low byte not held");
  a_drive_read: assert property (adOe |-> active && isRead && !pin_q.csN)
    else $error("data driven outside read");
  a_mux_latch: assert property (state_q != ACC_CLEAR && aleFall |=> style_q == tdm_host_pkg::STYLE_MUX && addrLatch_q == $past(pin_q.ad[1:0]))
    else $error("address not latched");
  a_err_cause: assert property (errOut |-> lossErr || (|ovr_q) || !lock_q)
    else $error("error without cause");
  a_loss_err: assert property (bclk_q[2] == bclk_q[1] [*8] ##1 bclk_q[2] == bclk_q[1] ##1 bclk_q[2] == bclk_q[1] |=> errOut)
    else $error("clock loss not flagged");
  a_dma_off: assert property (!ctrl_q[0] |=> !dmaRequestLine[0])
    else $error("request while disabled");
  a_clear_end: assert property (state_q == ACC_CLEAR && int'(clrIdx_q) == tdm_host_pkg::CHANNELS - 1 |=> state_q == ACC_IDLE)
    else $error("clear sweep overran");
  c_read_done: cover property (state_q == ACC_DONE && adOe);
  c_cm_write: cover property (cmWr);
  c_dma_ack: cover property (dmaRequestLine[0] ##1 !dmaRequestLine[0]);
  c_overrun: cover property ($rose(ovr_q[0]));
endmodule

/* File: hw/tdm_host_pkg.sv */
// Constants, types and field layout for the time-slot switch host port
// Overview of operation
// - Non-multiplexed styles take the register address from the two select inputs.
// - Multiplexed style ignores the select inputs; the host leaves them open.
// - Bus style is derived from the address latch strobe behaviour.
// - Multiplexed style latches the address from the shared lines at strobe fall.
// - Chip select low enables access; with it high only an address latch strobe fall is acted on.
// - Ready styles drive the data lines while read strobe and select are low; here only once the access reaches ACC_DONE.
// - Ready styles keep data lines as inputs and take data on write strobe.
// - Acknowledge style acts only while data strobe and chip select overlap.
// - Acknowledge style sets data line direction from the direction input.
// - Ready styles pull the open-drain ready line low until access completes.
// - Acknowledge style pulls the open-drain acknowledge low on completed transfer.
// - Error output high on bus clock loss, DMA overrun or PLL unlock.
// - With DMA enabled, each of two channels raises its request line.
// - Host reads and writes data memory, connection memory and control registers.
// - Memory accesses are served while the backplane bus keeps running.
// - The switch handles 384 channels: 256 backplane and 128 local.
// - Each channel carries one 8-bit sample per 8 kHz frame.
// - Shared lines carry data only, or address then data when multiplexed.
// - Connection low byte waits in a holding register; high write commits 12 bits.
// - Chip reset clears registers, connection memory and data memory.
package tdm_host_pkg;
  // ----------------------------------------------------------------
  // Channel plan and timing
  // ----------------------------------------------------------------
  localparam int CHANNELS = 384;
  localparam int BUS_CHANNELS = 256;
  localparam int LOCAL_CHANNELS = 128;
  localparam int SAMPLE_BITS = 8;
  localparam int CM_BITS = 12;
  localparam int CLK_PERIOD_NS = 100;
  localparam int FRAME_NS = 125000;
  localparam int FRAME_CYC = FRAME_NS / CLK_PERIOD_NS;
  localparam int LOSS_NS = 1000;
  localparam int LOSS_CYC = LOSS_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Register select codes and fields
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_IDX_LOW = 2'h0;
  localparam logic [1:0] REG_IDX_HIGH = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h3;
  localparam logic [1:0] SPACE_REG = 2'h0;
  localparam logic [1:0] SPACE_DM = 2'h1;
  localparam logic [1:0] SPACE_CML = 2'h2;
  localparam logic [1:0] SPACE_CMH = 2'h3;
  localparam int IDX_MSB_BIT = 0;
  localparam int SPACE_LSB = 1;
  localparam int CTRL_CLR_OVR_BIT = 7;
  localparam int CM_LOW_BITS = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] IDX_RST = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {STYLE_ACK, STYLE_READY, STYLE_MUX} busStyle_e;
  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic ale;
    logic [1:0] regSel;
    logic [7:0] ad;
  } hostPins_s;
endpackage

/* File: dv/dma_ctrl_model.sv */
// DMA controller model that answers the host port's per-channel request lines
`timescale 1ns/1ns
module dma_ctrl_model #(
  parameter int CH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CH-1:0] dmaRequestLine,
  input wire logic [CH-1:0] stall,
  input wire logic slow,
  output logic [CH-1:0] dmaAckLine
);
  // ----------------------------------------------------------------
  // Answer logic
  // ----------------------------------------------------------------
  logic [CH-1:0] ack_q;
  logic [4:0] cnt_q [CH];

  // Ack after a short or long delay; a stalled channel never answers,
  // which is how the bench provokes an overrun
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= '0;
      for (int c = 0; c < CH; c++) cnt_q[c] <= 5'h00;
    end else begin
      for (int c = 0; c < CH; c++) begin
        if (!dmaRequestLine[c]) begin
          cnt_q[c] <= 5'h00;
          ack_q[c] <= 1'b0; // Drop so the next answer is a fresh rising edge
        end else if (!stall[c]) begin
          if (cnt_q[c] != 5'h1f) cnt_q[c] <= cnt_q[c] + 5'h01;
          if (cnt_q[c] >= (slow ? 5'h14 : 5'h01)) ack_q[c] <= 1'b1;
        end
      end
    end
  end

  assign dmaAckLine = ack_q;
endmodule

/* File: dv/tdm_switch_host_port_tb.sv */
// Self-checking bench for the time-slot switch host port
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin mismatches++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module tdm_switch_host_port_tb;
  // ----------------------------------------------------------------
  // Pins and resolution
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] hostAd = 8'h00;
  logic [1:0] regSel = 2'h0;
  logic ale = 1'b1;
  logic csN = 1'b1;
  logic rdN = 1'b1;
  logic wrN = 1'b1;
  logic busClk = 1'b0;
  logic busRun = 1'b1;
  logic pllLocked = 1'b1;
  logic [1:0] stall = 2'h0;
  logic slow = 1'b0;
  logic muxMode = 1'b0;
  logic ackStyle = 1'b0;
  logic [7:0] adIn;
  logic [7:0] adOut;
  logic adOe;
  logic rdyOut;
  logic rdyOe;
  logic rdyPin;
  logic errOut;
  logic [1:0] dmaReq;
  logic [1:0] dmaAck;
  int mismatches = 0;
  int checksDone = 0;

  // Shared lines and the pulled-up open-drain handshake pin
  assign adIn = adOe ? adOut : hostAd;
  assign rdyPin = rdyOe ? rdyOut : 1'b1;

  // System clock, and a backplane clock that can be stopped
  always #50 clk = ~clk;
  always @(posedge clk) if (busRun) busClk <= ~busClk;

  tdm_host_port #(.DMA_CH(2)) i_dut (.clk(clk), .rst_n(rst_n), .adIn(adIn), .adOut(adOut), .adOe(adOe),
    .regSel(regSel), .ale(ale), .csN(csN), .readDataStrobeN(rdN), .writeRwN(wrN), .rdyTransferAckOut(rdyOut),
    .rdyTransferAckOe(rdyOe), .bus4MhzClock(busClk), .pllLocked(pllLocked), .errOut(errOut),
    .dmaRequestLine(dmaReq), .dmaAckLine(dmaAck));

  dma_ctrl_model #(.CH(2)) i_dma (.clk(clk), .rst_n(rst_n), .dmaRequestLine(dmaReq), .stall(stall),
    .slow(slow), .dmaAckLine(dmaAck));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task end_of_test;
    if (mismatches == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic doReset(input logic aleLvl);
    @(posedge clk);
    ale <= aleLvl; // Level seen during the sweep straps the style
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (400) @(posedge clk); // Memory sweep takes 384 cycles
  endtask

  // One access in whatever style is active; strobes held until the answer
  task automatic acc(input logic [1:0] a, input logic wr, input logic [7:0] wd, output logic [7:0] rdv);
    int n;
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    if (muxMode) begin
      ale <= 1'b1;
      hostAd <= {6'h00, a};
      regSel <= ~a; // Wrong on purpose, must be ignored
      @(posedge clk);
      ale <= 1'b0;
      repeat (3) @(posedge clk);
    end else begin
      regSel <= a;
    end
    hostAd <= wr ? wd : ~hostAd;
    csN <= 1'b0;
    rdN <= ackStyle ? 1'b0 : wr;
    wrN <= ~wr;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (rdyPin === 1'b0) seen = 1'b1;
      if (ackStyle ? seen : (seen && rdyPin === 1'b1)) break;
    end
    `CHK("completion", 1'b1, seen && n < 40)
    `CHK("data drive", ~wr, adOe)
    rdv = adOut;
    @(posedge clk);
    csN <= 1'b1;
    rdN <= 1'b1;
    wrN <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Indirect access: index low, index high with space, then data window
  task automatic memAcc(input logic [1:0] sp, input logic [8:0] idx, input logic wr, input logic [7:0] wd,
                        output logic [7:0] rdv);
    logic [7:0] d;
    acc(tdm_host_pkg::REG_IDX_LOW, 1'b1, idx[7:0], d);
    acc(tdm_host_pkg::REG_IDX_HIGH, 1'b1, {5'h00, sp, idx[8]}, d);
    acc(tdm_host_pkg::REG_DATA, wr, wd, rdv);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_mem;
    logic [7:0] r;
    memAcc(tdm_host_pkg::SPACE_DM, 9'h005, 1'b0, 8'h00, r);
    `CHK("dm cleared", 8'h00, r)
    memAcc(tdm_host_pkg::SPACE_DM, 9'h17f, 1'b1, 8'ha5, r);
    memAcc(tdm_host_pkg::SPACE_DM, 9'h17f, 1'b0, 8'h00, r);
    `CHK("dm last", 8'ha5, r)
    memAcc(tdm_host_pkg::SPACE_DM, 9'h180, 1'b1, 8'h5a, r);
    memAcc(tdm_host_pkg::SPACE_DM, 9'h180, 1'b0, 8'h00, r);
    `CHK("dm beyond", 8'h00, r)
  endtask

  task automatic t_conn;
    logic [7:0] r;
    memAcc(tdm_host_pkg::SPACE_CML, 9'h00a, 1'b1, 8'h3c, r);
    memAcc(tdm_host_pkg::SPACE_CML, 9'h00a, 1'b0, 8'h00, r);
    `CHK("cm low held", 8'h00, r)
    memAcc(tdm_host_pkg::SPACE_CMH, 9'h00a, 1'b1, 8'h05, r);
    memAcc(tdm_host_pkg::SPACE_CML, 9'h00a, 1'b0, 8'h00, r);
    `CHK("cm low", 8'h3c, r)
    memAcc(tdm_host_pkg::SPACE_CMH, 9'h00a, 1'b0, 8'h00, r);
    `CHK("cm high", 4'h5, r[3:0])
  endtask

  // Write strobe with select high must leave memory and pins alone
  task automatic t_cs;
    logic [7:0] r;
    memAcc(tdm_host_pkg::SPACE_DM, 9'h17f, 1'b0, 8'h00, r);
    @(posedge clk);
    regSel <= tdm_host_pkg::REG_DATA;
    hostAd <= 8'hff;
    wrN <= 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1;
      `CHK("cs high pins", 2'b00, {rdyOe, adOe})
    end
    @(posedge clk);
    wrN <= 1'b1;
    repeat (3) @(posedge clk);
    acc(tdm_host_pkg::REG_DATA, 1'b0, 8'h00, r);
    `CHK("cs high write", 8'ha5, r)
  endtask

  task automatic t_err;
    logic [7:0] r;
    `CHK("err idle", 1'b0, errOut)
    @(posedge clk);
    busRun <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    `CHK("err clock loss", 1'b1, errOut)
    memAcc(tdm_host_pkg::SPACE_REG, 9'h000, 1'b0, 8'h00, r);
    `CHK("loss flag", 1'b1, r[7])
    @(posedge clk);
    busRun <= 1'b1;
    pllLocked <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    `CHK("err unlock", 1'b1, errOut)
    memAcc(tdm_host_pkg::SPACE_REG, 9'h000, 1'b0, 8'h00, r);
    `CHK("unlock flag", 1'b1, r[6])
    @(posedge clk);
    pllLocked <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    `CHK("err cleared", 1'b0, errOut)
  endtask

  // Prompt answer, slow answer, then a stalled channel overruns
  task automatic t_dma;
    logic [7:0] r;
    int n;
    acc(tdm_host_pkg::REG_CTRL, 1'b1, 8'h03, r);
    for (n = 0; n < 1300 && dmaReq !== 2'b11; n++) @(posedge clk);
    `CHK("dma request", 2'b11, dmaReq)
    repeat (30) @(posedge clk);
    `CHK("dma answered", 2'b00, dmaReq)
    slow <= 1'b1;
    stall <= 2'b10;
    for (n = 0; n < 1300 && dmaReq[0] !== 1'b1; n++) @(posedge clk);
    repeat (40) @(posedge clk);
    `CHK("dma slow", 2'b10, dmaReq)
    for (n = 0; n < 1300 && dmaReq[0] !== 1'b1; n++) @(posedge clk);
    repeat (5) @(posedge clk);
    `CHK("err overrun", 1'b1, errOut)
    memAcc(tdm_host_pkg::SPACE_REG, 9'h000, 1'b0, 8'h00, r);
    `CHK("overrun flags", 6'h02, r[5:0])
    stall <= 2'b00;
    acc(tdm_host_pkg::REG_CTRL, 1'b1, 8'h80, r);
    repeat (5) @(posedge clk);
    `CHK("overrun cleared", 1'b0, errOut)
  endtask

  task automatic t_mux;
    logic [7:0] r;
    muxMode = 1'b1;
    memAcc(tdm_host_pkg::SPACE_DM, 9'h033, 1'b1, 8'hc3, r);
    memAcc(tdm_host_pkg::SPACE_DM, 9'h033, 1'b0, 8'h00, r);
    `CHK("mux data", 8'hc3, r)
  endtask

  task automatic t_ack;
    logic [7:0] r;
    muxMode = 1'b0;
    ackStyle = 1'b1;
    doReset(1'b0);
    memAcc(tdm_host_pkg::SPACE_DM, 9'h17f, 1'b0, 8'h00, r);
    `CHK("reset clears", 8'h00, r)
    memAcc(tdm_host_pkg::SPACE_DM, 9'h100, 1'b1, 8'h69, r);
    memAcc(tdm_host_pkg::SPACE_DM, 9'h100, 1'b0, 8'h00, r);
    `CHK("ack data", 8'h69, r)
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    doReset(1'b1);
    t_mem;
    t_conn;
    t_cs;
    t_err;
    t_dma;
    t_mux;
    t_ack;
    end_of_test;
  end

  // The run needs about 4400 cycles; allow well over six times that
  initial begin
    #3000000;
    mismatches++;
    end_of_test;
  end
endmodule
